//--- dimap_top.sv
`timescale 1ns/1ps
`include "dimap_defs.svh"

module dimap_top #(
   parameter int DEB_CYCLES = `DIMAP_DEB_CYCLES
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // contacts and controller state
   input wire logic [`DIMAP_NUM_IN-1:0] DI_IN,
   input wire logic AUTOTUNE_ACTIVE,
   // function results
   output logic RUN_STATE,
   output logic FORCED_RESET,
   output logic HOLD_CONTROL,
   output logic STEP_ADVANCE,
   output logic FIX_MODE,
   output logic MANUAL_OUTPUT,
   output logic [`DIMAP_NUM_IN-1:0] LOGIC_OPERAND,
   output logic [4:0] START_PATTERN,
   output logic [`DIMAP_NUM_IN-1:0] DI_MONITOR
);

   localparam int NI = `DIMAP_NUM_IN;
   localparam int CW = $clog2(DEB_CYCLES + 1);
   localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYCLES - 1);
   logic [NI-1:0] sync1_reg, sync2_reg, deb_reg, deb_prev_reg, mon_reg;
   logic [CW-1:0] cnt_reg [NI];
   logic [3:0] cfg_reg [1:NI-1];
   logic sel_reg, panel_hold_reg, panel_fix_reg, panel_manual_reg;
   logic [4:0] panel_pat_reg;
   logic ctl_wr;
   dimap_pkg::dimap_fn_e eff [NI];
   logic pat_bound;
   int pat_base, pat_n;
   logic [NI-1:0] pat_lock, pat_lock_reg;
   logic [11:0] fn_bound, fn_lvl, retain_reg, retain_next;
   logic [NI-1:0] logic_next;
   logic [4:0] pat_raw;
   logic run_reg, force_reg, hold_reg, adv_reg, adv_prev_reg, fix_reg, manual_reg;
   logic run_next, force_next, hold_next, fix_next, manual_next, adv_rise;
   logic [NI-1:0] logic_reg;
   logic [4:0] pat_reg;
   logic [31:0] rdata_reg;
   // a binding legal only at its permitted input positions
   function automatic dimap_pkg::dimap_fn_e legal_fn(input logic [3:0] code, input int pos);
      dimap_pkg::dimap_fn_e fn;
      fn = dimap_pkg::dimap_fn_e'(code);
      if (code > 4'(dimap_pkg::FN_PAT5) || fn == dimap_pkg::FN_RUN_RST) begin
         fn = dimap_pkg::FN_NONE;
      end else if ((fn == dimap_pkg::FN_PAT2 || fn == dimap_pkg::FN_PAT3) &&
                   pos != `DIMAP_PAT_POS_LO && pos != `DIMAP_PAT_POS_HI) begin
         fn = dimap_pkg::FN_NONE;
      end else if ((fn == dimap_pkg::FN_PAT4 || fn == dimap_pkg::FN_PAT5) &&
                   pos != `DIMAP_PAT_POS_LO) begin
         fn = dimap_pkg::FN_NONE;
      end
      return fn;
   endfunction
   // number of inputs a pattern binding occupies, zero for others
   function automatic int pat_width(input dimap_pkg::dimap_fn_e fn);
      case (fn)
         dimap_pkg::FN_PAT2: return 2;
         dimap_pkg::FN_PAT3: return 3;
         dimap_pkg::FN_PAT4: return 4;
         dimap_pkg::FN_PAT5: return 5;
         default: return 0;
      endcase
   endfunction
   // clamp to the pattern count of the width; zero means pattern one
   function automatic dimap_pkg::dimap_pat_t pat_decode(input logic [4:0] raw, input int n);
      logic [4:0] mx, v;
      case (n)
         2: mx = `DIMAP_PAT_MAX2;
         3: mx = `DIMAP_PAT_MAX3;
         4: mx = `DIMAP_PAT_MAX4;
         default: mx = `DIMAP_PAT_MAX5;
      endcase
      v = (raw > mx) ? mx : raw;
      if (v == 5'h00) begin
         v = `DIMAP_RST_PAT;
      end
      return v;
   endfunction
   // two-stage synchroniser; stage one feeds stage two only
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= DI_IN;
         sync2_reg <= sync1_reg;
      end
   end
   // stability counter per input; any bounce restarts the wait
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         deb_reg <= '0;
         cnt_reg <= '{default: '0};
      end else begin
         for (int i = 0; i < NI; i++) begin
            if (sync2_reg[i] == deb_reg[i]) begin
               cnt_reg[i] <= '0;
            end else if (cnt_reg[i] == DEB_LAST) begin
               deb_reg[i] <= sync2_reg[i];
               cnt_reg[i] <= '0;
            end else begin
               cnt_reg[i] <= cnt_reg[i] + 1'b1;
            end
         end
      end
   end
   // previous debounced levels for edge detection, plus monitor copy
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         deb_prev_reg <= '0;
         mon_reg <= '0;
      end else begin
         deb_prev_reg <= deb_reg;
         mon_reg <= deb_reg;
      end
   end
   // assignment registers for inputs 2 to 10
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         cfg_reg <= '{default: 4'h0};
      end else if (WR && ADDR == `DIMAP_OFS_ASSIGN_LO) begin
         for (int i = 1; i < NI - 1; i++) begin
            cfg_reg[i] <= WDATA[4*(i-1) +: 4];
         end
      end else if (WR && ADDR == `DIMAP_OFS_ASSIGN_HI) begin
         cfg_reg[NI-1] <= WDATA[3:0];
      end
   end
   assign ctl_wr = WR && ADDR == `DIMAP_OFS_CONTROL;
   // control register: indicator and front-panel settings
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         sel_reg <= 1'b0;
         panel_hold_reg <= 1'b0;
         panel_fix_reg <= 1'b0;
         panel_manual_reg <= 1'b0;
         panel_pat_reg <= `DIMAP_RST_PAT;
      end else if (ctl_wr) begin
         sel_reg <= WDATA[`DIMAP_CTL_SEL_BIT];
         panel_hold_reg <= WDATA[`DIMAP_CTL_HOLD_BIT];
         panel_fix_reg <= WDATA[`DIMAP_CTL_FIX_BIT];
         panel_manual_reg <= WDATA[`DIMAP_CTL_MANUAL_BIT];
         panel_pat_reg <= WDATA[`DIMAP_CTL_PAT_LSB +: 5];
      end
   end
   // resolve bindings: legality, pattern ownership, occupied inputs
   always_comb begin
      pat_bound = 1'b0;
      pat_base = 0;
      pat_n = 0;
      pat_lock = '0;
      eff[0] = dimap_pkg::FN_RUN_RST;
      for (int i = 1; i < NI; i++) begin
         eff[i] = legal_fn(cfg_reg[i], i);
      end
      // the lower position wins when both carry a pattern binding
      if (pat_width(eff[`DIMAP_PAT_POS_LO]) != 0) begin
         pat_bound = 1'b1;
         pat_base = `DIMAP_PAT_POS_LO;
         pat_n = pat_width(eff[`DIMAP_PAT_POS_LO]);
      end else if (pat_width(eff[`DIMAP_PAT_POS_HI]) != 0) begin
         pat_bound = 1'b1;
         pat_base = `DIMAP_PAT_POS_HI;
         pat_n = pat_width(eff[`DIMAP_PAT_POS_HI]);
      end
      for (int i = 1; i < NI; i++) begin
         if (pat_bound && i >= pat_base && i < pat_base + pat_n) begin
            pat_lock[i] = 1'b1;
            if (i != pat_base) begin
               eff[i] = dimap_pkg::FN_NONE;
            end
         end else if (pat_width(eff[i]) != 0) begin
            eff[i] = dimap_pkg::FN_NONE;
         end
      end
   end
   // per function: lowest input wins, loop runs downward to let it overwrite
   always_comb begin
      fn_bound = '0;
      fn_lvl = '0;
      logic_next = '0;
      for (int i = NI - 1; i >= 0; i--) begin
         if (eff[i] != dimap_pkg::FN_NONE) begin
            fn_bound[eff[i]] = 1'b1;
            fn_lvl[eff[i]] = deb_reg[i];
         end
      end
      // each logic input is its own operand; unbinding drops it at once
      for (int i = 0; i < NI; i++) begin
         logic_next[i] = eff[i] == dimap_pkg::FN_LOGIC_OPERAND && deb_reg[i];
      end
   end
   // retention memory: set while bound, freed by the next control write
   assign retain_next = fn_bound | (retain_reg & {12{~ctl_wr}});
   // pattern bits taken from consecutive inputs, first one weight 1
   always_comb begin
      pat_raw = 5'h00;
      for (int k = 0; k < 5; k++) begin
         if (k < pat_n && pat_base + k < NI) begin
            pat_raw[k] = deb_reg[pat_base+k];
         end
      end
   end
   // level function: input wins over panel, unbound keeps last value while retained, else panel
   function automatic logic lvl_next(input logic bound, input logic lvl, input logic cur,
                                     input logic held, input logic panel);
      if (bound) begin
         return lvl;
      end else if (held) begin
         return cur;
      end
      return panel;
   endfunction
   // next state of the controller functions
   always_comb begin
      force_next = lvl_next(fn_bound[dimap_pkg::FN_FORCE_RST], fn_lvl[dimap_pkg::FN_FORCE_RST],
                            force_reg, retain_reg[dimap_pkg::FN_FORCE_RST], 1'b0);
      hold_next = lvl_next(fn_bound[dimap_pkg::FN_HOLD_CONTROL],
                           fn_lvl[dimap_pkg::FN_HOLD_CONTROL], hold_reg,
                           retain_reg[dimap_pkg::FN_HOLD_CONTROL], panel_hold_reg);
      fix_next = lvl_next(fn_bound[dimap_pkg::FN_FIX], fn_lvl[dimap_pkg::FN_FIX], fix_reg,
                          retain_reg[dimap_pkg::FN_FIX], panel_fix_reg);
      // autotune freezes the manual state rather than forcing it off
      if (AUTOTUNE_ACTIVE) begin
         manual_next = manual_reg;
      end else begin
         manual_next = lvl_next(fn_bound[dimap_pkg::FN_MANUAL_OUTPUT],
                                fn_lvl[dimap_pkg::FN_MANUAL_OUTPUT], manual_reg,
                                retain_reg[dimap_pkg::FN_MANUAL_OUTPUT], panel_manual_reg);
      end
      // forced reset overrides run and an input one edge under it is lost; no other function blocks the toggle
      if (force_next) begin
         run_next = 1'b0;
      end else if (deb_reg[0] && !deb_prev_reg[0]) begin
         run_next = !run_reg;
      end else begin
         run_next = run_reg;
      end
      adv_rise = fn_bound[dimap_pkg::FN_STEP_ADVANCE] &&
                 fn_lvl[dimap_pkg::FN_STEP_ADVANCE] && !adv_prev_reg;
   end
   // controller function state
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         run_reg <= 1'b0;
         force_reg <= 1'b0;
         hold_reg <= 1'b0;
         fix_reg <= 1'b0;
         manual_reg <= 1'b0;
         logic_reg <= '0;
         retain_reg <= '0;
      end else begin
         run_reg <= run_next;
         force_reg <= force_next;
         hold_reg <= hold_next;
         fix_reg <= fix_next;
         manual_reg <= manual_next;
         logic_reg <= logic_next;
         retain_reg <= retain_next;
      end
   end
   // step advance pulse, one cycle per on edge, suppressed under hold
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         adv_reg <= 1'b0;
         adv_prev_reg <= 1'b0;
      end else begin
         adv_prev_reg <= fn_bound[dimap_pkg::FN_STEP_ADVANCE] &&
                         fn_lvl[dimap_pkg::FN_STEP_ADVANCE];
         adv_reg <= adv_rise && !hold_reg;
      end
   end
   // start pattern: external when enabled and bound, then frozen in fixed mode; panel pattern otherwise, even in fixed mode
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         pat_reg <= `DIMAP_RST_PAT;
         pat_lock_reg <= '0;
      end else begin
         pat_lock_reg <= pat_lock;
         if (sel_reg && pat_bound) begin
            if (!fix_reg) begin
               pat_reg <= pat_decode(pat_raw, pat_n);
            end
         end else begin
            pat_reg <= pat_decode(panel_pat_reg, 5);
         end
      end
   end
   // read port: data only in the cycle after the strobe, unmapped reads zero
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         rdata_reg <= 32'h0000_0000;
      end else if (!RD) begin
         rdata_reg <= 32'h0000_0000;
      end else if (ADDR == `DIMAP_OFS_ASSIGN_LO) begin
         for (int i = 1; i < NI - 1; i++) begin
            rdata_reg[4*(i-1) +: 4] <= cfg_reg[i];
         end
      end else if (ADDR == `DIMAP_OFS_ASSIGN_HI) begin
         rdata_reg <= {28'h000_0000, cfg_reg[NI-1]};
      end else if (ADDR == `DIMAP_OFS_CONTROL) begin
         rdata_reg <= {23'h00_0000, panel_pat_reg, panel_manual_reg, panel_fix_reg,
                       panel_hold_reg, sel_reg};
      end else if (ADDR == `DIMAP_OFS_STATUS) begin
         rdata_reg <= {12'h000, pat_reg, manual_reg, fix_reg, hold_reg, force_reg, run_reg,
                       mon_reg};
      end else if (ADDR == `DIMAP_OFS_LOCK) begin
         rdata_reg <= {6'h00, pat_lock_reg, 4'h0, fn_bound};
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end
   // outputs straight from flip-flops
   assign RDATA = rdata_reg;
   assign RUN_STATE = run_reg;
   assign FORCED_RESET = force_reg;
   assign HOLD_CONTROL = hold_reg;
   assign STEP_ADVANCE = adv_reg;
   assign FIX_MODE = fix_reg;
   assign MANUAL_OUTPUT = manual_reg;
   assign LOGIC_OPERAND = logic_reg;
   assign START_PATTERN = pat_reg;
   assign DI_MONITOR = mon_reg;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   sequence run_edge_s;
      !deb_prev_reg[0] && deb_reg[0];
   endsequence
   sequence free_of_force_s;
      !force_next;
   endsequence
   run_toggle_a: assert property ((run_edge_s and free_of_force_s) |=>
      run_reg != $past(run_reg)) else $error("run state did not toggle on input one edge");
   force_reset_a: assert property (force_reg |-> !run_reg)
      else $error("run active during forced reset");
   advance_hold_a: assert property (adv_reg |-> !$past(hold_reg))
      else $error("step advance while hold active");
   manual_block_a: assert property (AUTOTUNE_ACTIVE |=> $stable(manual_reg))
      else $error("manual state changed during autotune");
   pattern_nonzero_a: assert property (pat_reg != 5'h00)
      else $error("start pattern is zero");
   pattern_fix_a: assert property ((fix_reg && sel_reg && pat_bound) |=>
      $stable(pat_reg)) else $error("pattern changed in fixed mode");
   debounce_wait_a: assert property ($changed(deb_reg[0]) |->
      $past(cnt_reg[0]) == DEB_LAST) else $error("input one changed before stable time");
   monitor_follow_a: assert property (mon_reg == $past(deb_reg))
      else $error("monitor does not follow debounced input");
   pattern_lock_a: assert property ((eff[4] == dimap_pkg::FN_PAT5) |=>
      pat_lock_reg[8:4] == 5'h1F) else $error("five-bit pattern inputs not locked");
   operand_drop_a: assert property ((eff[3] != dimap_pkg::FN_LOGIC_OPERAND) |=>
      !logic_reg[3]) else $error("logic operand kept after unbinding");
endmodule // dimap_top

//--- dimap_defs.svh
// Contract
// - input 1 is always run/reset toggle; other functions only on inputs 2 to 10
// - 2/3-bit pattern select only on inputs 5 or 8; 4/5-bit only on 5
// - monitor shows each input's debounced state, bound or not
// - run/reset toggles on the rising edge, never blocked; the code forces run off and drops an edge that comes under forced reset
// - forced reset holds reset for as long as its input is on
// - hold suspends control while on, restarts when off
// - step advance acts on rising edge, ignored while hold is active
// - fixed-value mode while on, program mode while off
// - manual output while on, blocked while autotune runs
// - logic-source inputs only feed the event logic operands
// - pattern select offers 3/7/15/20 patterns, blocked in fixed-value mode
// - a function never acts while its blocking function is active
// - edge function starts on an on edge, persists, next on edge cancels
// - a level counts only after 0.1 s of stability
// - a function bound to an input ignores the panel setting
// - duplicate bindings: lowest-numbered input wins, others ignored
// - a multi-bit pattern binding clears bindings on the inputs it occupies
// - unbinding keeps the running action, except logic operands stop at once
// - 5-bit pattern on input 5 takes inputs 5 to 9 and marks them locked
// - pattern number is binary, input 5 weight 1 up to input 9 weight 16
// - decoded pattern zero becomes pattern one
// - external pattern selection needs the external selection indicator enabled
`ifndef DIMAP_DEFS_SVH
`define DIMAP_DEFS_SVH
`define DIMAP_NUM_IN 10
`define DIMAP_CLK_KHZ 250000
`define DIMAP_DEB_TIME_MS 100
`define DIMAP_DEB_CYCLES (`DIMAP_DEB_TIME_MS * `DIMAP_CLK_KHZ)
`define DIMAP_OFS_ASSIGN_LO 8'h00
`define DIMAP_OFS_ASSIGN_HI 8'h04
`define DIMAP_OFS_CONTROL 8'h08
`define DIMAP_OFS_STATUS 8'h0C
`define DIMAP_OFS_LOCK 8'h10
`define DIMAP_CTL_SEL_BIT 0
`define DIMAP_CTL_HOLD_BIT 1
`define DIMAP_CTL_FIX_BIT 2
`define DIMAP_CTL_MANUAL_BIT 3
`define DIMAP_CTL_PAT_LSB 4
`define DIMAP_RST_PAT 5'h01
`define DIMAP_PAT_POS_LO 4
`define DIMAP_PAT_POS_HI 7
`define DIMAP_PAT_MAX2 5'h03
`define DIMAP_PAT_MAX3 5'h07
`define DIMAP_PAT_MAX4 5'h0F
`define DIMAP_PAT_MAX5 5'h14
`endif

//--- dimap_pkg.sv
package dimap_pkg;
   // function codes as written into the assignment registers
   typedef enum logic [3:0] {
      FN_NONE, FN_RUN_RST, FN_FORCE_RST, FN_HOLD_CONTROL, FN_STEP_ADVANCE, FN_FIX,
      FN_MANUAL_OUTPUT, FN_LOGIC_OPERAND, FN_PAT2, FN_PAT3, FN_PAT4, FN_PAT5
   } dimap_fn_e;
   typedef logic [4:0] dimap_pat_t;
endpackage

//--- dimap_contacts_model.sv
`timescale 1ns/1ps

module dimap_contacts_model #(
   parameter int HOLD_CYCLES = 12
) (
   // clock of the block, used only to pace switch changes
   input wire logic clk,
   // contact levels, 1 = shorted to common
   output logic [9:0] di
);
   int unsigned cyc = 0;
   int unsigned last_cyc = 0;

   // contacts start open; cycle count paces the next change
   initial di = 10'h000;
   always @(posedge clk) cyc <= cyc + 1;

   // a real switch settles before moving again, so each level stands long enough
   task automatic set_level(input logic [9:0] v);
      while (cyc - last_cyc < HOLD_CYCLES) @(posedge clk);
      @(posedge clk);
      di <= v;
      last_cyc = cyc;
   endtask

   // contact bounce: a short flip that the block must not take as a change
   task automatic bounce(input logic [9:0] mask, input int n);
      @(posedge clk);
      di <= di ^ mask;
      repeat (n) @(posedge clk);
      di <= di ^ mask;
      last_cyc = cyc;
   endtask
endmodule // dimap_contacts_model

//--- dimap_tb.sv
`timescale 1ns/1ps
`include "dimap_defs.svh"

module testbench;
   localparam int DEB = 8;
   // clock and reset
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   // register port
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] RDATA;
   // contacts and results
   logic [9:0] DI_IN;
   logic AUTOTUNE_ACTIVE = 1'b0;
   logic RUN_STATE, FORCED_RESET, HOLD_CONTROL, STEP_ADVANCE, FIX_MODE, MANUAL_OUTPUT;
   logic [9:0] LOGIC_OPERAND, DI_MONITOR;
   logic [4:0] START_PATTERN;
   int failures = 0;
   int n_checks = 0;
   int adv_cnt = 0;
   int adv0;
   logic [4:0] pat_in [4] = '{5'h00, 5'h05, 5'h14, 5'h1F};
   logic [4:0] pat_out [4] = '{5'h01, 5'h05, 5'h14, 5'h14};
   logic [4:0] pat_max [4] = '{5'h03, 5'h07, 5'h0F, 5'h14};

   always #2 SYS_CLK = ~SYS_CLK;

   dimap_contacts_model #(.HOLD_CYCLES(DEB + 4)) i_contacts (.clk(SYS_CLK), .di(DI_IN));

   dimap_top #(.DEB_CYCLES(DEB)) i_dut (
      .SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .DI_IN(DI_IN), .AUTOTUNE_ACTIVE(AUTOTUNE_ACTIVE),
      .RUN_STATE(RUN_STATE), .FORCED_RESET(FORCED_RESET), .HOLD_CONTROL(HOLD_CONTROL),
      .STEP_ADVANCE(STEP_ADVANCE), .FIX_MODE(FIX_MODE), .MANUAL_OUTPUT(MANUAL_OUTPUT),
      .LOGIC_OPERAND(LOGIC_OPERAND), .START_PATTERN(START_PATTERN),
      .DI_MONITOR(DI_MONITOR)
   );

   // advance is a one-cycle pulse, so count pulses instead of sampling the level
   always @(posedge SYS_CLK) if (STEP_ADVANCE === 1'b1) adv_cnt <= adv_cnt + 1;

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic check_reg(input logic [7:0] a, input logic [31:0] mask, exp);
      logic [31:0] d;
      @(posedge SYS_CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 d = RDATA;
      n_checks++;
      if ((d & mask) !== exp) begin
         failures++;
         $display("BAD %0t read %h got %h want %h", $time, a, d & mask, exp);
      end
   endtask

   task automatic check_pin(input logic [31:0] got, exp, input string what);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // move the contacts, then let sync, debounce and output stages settle
   task automatic contacts(input logic [9:0] v);
      i_contacts.set_level(v);
      repeat (DEB + 6) @(posedge SYS_CLK);
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // watchdog: the tests need well under 3000 cycles
   initial begin
      #80000;
      failures++;
      $display("BAD %0t watchdog expired", $time);
      report_and_stop;
   end

   initial begin
      repeat (6) @(posedge SYS_CLK);
      RST <= 1'b0;
      // reset values and refused accesses
      check_pin(START_PATTERN, 1, "reset pattern");
      check_reg(`DIMAP_OFS_ASSIGN_LO, 32'hFFFFFFFF, 0);
      check_reg(8'h24, 32'hFFFFFFFF, 0);
      wr(`DIMAP_OFS_STATUS, 32'hFFFFFFFF);
      check_reg(`DIMAP_OFS_STATUS, 32'hFFFFFFFF, 32'h00008000);
      $display("test reset done");
      // run/reset toggle on input 1, monitor of an unbound input, bounce
      contacts(10'h001);
      check_pin(RUN_STATE, 1, "run on edge");
      check_pin(DI_MONITOR, 10'h001, "monitor");
      contacts(10'h200);
      check_pin(RUN_STATE, 1, "run persists");
      check_pin(DI_MONITOR, 10'h200, "monitor unbound");
      contacts(10'h001);
      check_pin(RUN_STATE, 0, "run cancel");
      i_contacts.bounce(10'h001, DEB - 3);
      repeat (DEB + 6) @(posedge SYS_CLK);
      check_pin(RUN_STATE, 0, "bounce ignored");
      contacts(10'h000);
      $display("test run toggle done");
      // forced reset, hold, step advance blocked by hold, panel lock
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h00000432);
      contacts(10'h002);
      check_pin(FORCED_RESET, 1, "forced reset");
      wr(`DIMAP_OFS_CONTROL, 32'h00000002);
      repeat (3) @(posedge SYS_CLK);
      check_pin(HOLD_CONTROL, 0, "panel hold locked");
      contacts(10'h004);
      check_pin(FORCED_RESET, 0, "forced reset off");
      check_pin(HOLD_CONTROL, 1, "hold on");
      adv0 = adv_cnt;
      contacts(10'h00C);
      check_pin(adv_cnt, adv0, "advance under hold");
      contacts(10'h008);
      check_pin(HOLD_CONTROL, 0, "hold restart");
      contacts(10'h000);
      contacts(10'h008);
      check_pin(adv_cnt, adv0 + 1, "one advance");
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h00000001);
      contacts(10'h002);
      check_pin(RUN_STATE, 0, "run code off input 1");
      contacts(10'h000);
      $display("test hold and advance done");
      // manual under autotune, fixed mode, logic operand and its unbinding
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h00065000);
      wr(`DIMAP_OFS_CONTROL, 32'h00000000);
      AUTOTUNE_ACTIVE <= 1'b1;
      contacts(10'h020);
      check_pin(MANUAL_OUTPUT, 0, "manual blocked");
      AUTOTUNE_ACTIVE <= 1'b0;
      repeat (3) @(posedge SYS_CLK);
      check_pin(MANUAL_OUTPUT, 1, "manual on");
      contacts(10'h030);
      check_pin(FIX_MODE, 1, "fix mode");
      contacts(10'h000);
      check_pin({FIX_MODE, MANUAL_OUTPUT}, 0, "fix and manual off");
      wr(`DIMAP_OFS_ASSIGN_HI, 32'h00000007);
      contacts(10'h200);
      check_pin(LOGIC_OPERAND, 10'h200, "operand");
      wr(`DIMAP_OFS_ASSIGN_HI, 32'h00000000);
      repeat (3) @(posedge SYS_CLK);
      check_pin(LOGIC_OPERAND, 0, "operand unbound");
      $display("test level functions done");
      // every pattern width on input 5 with all bits on, saturating
      // free inputs 5 and 6 first, so the control write drops their kept levels
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h00000000);
      wr(`DIMAP_OFS_CONTROL, 32'h00000001);
      contacts(10'h1F0);
      for (int k = 0; k < 4; k++) begin
         wr(`DIMAP_OFS_ASSIGN_LO, 32'(8 + k) << 12);
         repeat (4) @(posedge SYS_CLK);
         check_pin(START_PATTERN, pat_max[k], "pattern width");
      end
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h09009000);
      repeat (4) @(posedge SYS_CLK);
      check_pin(START_PATTERN, 5'h07, "lowest input wins");
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h08000000);
      repeat (4) @(posedge SYS_CLK);
      check_pin(START_PATTERN, 5'h03, "two bits on input 8");
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h0A000000);
      repeat (4) @(posedge SYS_CLK);
      check_pin(START_PATTERN, 5'h01, "four bits refused on 8");
      // five-bit selection clears the manual binding on input 6
      wr(`DIMAP_OFS_ASSIGN_LO, 32'h0006B000);
      check_reg(`DIMAP_OFS_LOCK, 32'h03FF0000, 32'h01F00000);
      check_reg(`DIMAP_OFS_LOCK, 32'h00000840, 32'h00000800);
      for (int k = 0; k < 4; k++) begin
         contacts({1'b0, pat_in[k], 4'h0});
         check_pin(START_PATTERN, pat_out[k], "decoded pattern");
      end
      check_pin(MANUAL_OUTPUT, 0, "input 6 taken by pattern");
      wr(`DIMAP_OFS_CONTROL, 32'h00000005);
      contacts(10'h050);
      check_pin(START_PATTERN, 5'h14, "frozen in fixed mode");
      wr(`DIMAP_OFS_CONTROL, 32'h00000030);
      repeat (4) @(posedge SYS_CLK);
      check_pin(START_PATTERN, 5'h03, "panel pattern");
      $display("test patterns done");
      report_and_stop;
   end
endmodule // testbench
